// *** common/tsc_pkg.sv ***
// Package with register map, field positions and timing for the sensor block
package tsc_pkg;
  // Command bytes
  localparam logic [7:0] CMD_TEMP = 8'h01;
  localparam logic [7:0] CMD_SETUP = 8'h03;
  localparam logic [7:0] CMD_MAKER = 8'hFE;
  localparam logic [7:0] CMD_REV = 8'hFF;
  // Setup register field
  localparam int HALT_BIT = 6;
  localparam logic HALT_RESET = 1'b0;
  // Reset values, fault full-scale value and unmapped read value
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] FULL_SCALE = 8'h7F;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Conversion time
  localparam int CONV_TIME_US = 100;
  localparam int CLOCK_MHZ = 10;
  localparam int CONV_CYCLES = CONV_TIME_US * CLOCK_MHZ;
  localparam int CONV_W = 16;
  typedef enum logic [1:0] {
    TSC_IDLE,
    TSC_CONVERT,
    TSC_HALTED
  } tsc_conv_state_t;
endpackage

// *** src/tsc_conv_timer.sv ***
// Conversion timer that counts one conversion period
`timescale 1ns/100ps
module tsc_conv_timer #(
  parameter int COUNT = tsc_pkg::CONV_CYCLES
) (
  clock,
  reset,
  restart,
  run,
  done
);
  import tsc_pkg::*;
  input wire logic clock;
  input wire logic reset;
  input wire logic restart;
  input wire logic run;
  output logic done;

  localparam logic [CONV_W-1:0] LAST = CONV_W'(COUNT - 1);
  logic [CONV_W-1:0] count;
  logic [CONV_W-1:0] next_count;
  logic next_done;

  // Count while running, restart on abort
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (restart || !run) begin
      next_count = '0;
    end else if (count == LAST) begin
      next_count = '0;
      next_done = 1'b1;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule // tsc_conv_timer

// *** src/tsc_regs.sv ***
// Register bank of the remote-diode sensor: setup, result and id registers
`timescale 1ns/100ps
// How it works
// - Halt bit clear runs the converter; set halts it in low power.
// - After reset the halt bit is zero, device not halted.
// - Any setup write aborts a running conversion and drops its result.
// - After a setup write, conversion restarts unless halt is set.
// - Result keeps its reset value until the first conversion ends.
// - Command FE reads a fixed maker code.
// - Command FF reads a fixed revision number.
// - Halting stops conversion, registers and last result stay.
// - Command byte selects which register the data byte targets.
// - Result is 8-bit two's complement, one degree per bit.
// - A diode fault at conversion end loads +127 full scale.
module tsc_regs #(
  parameter logic [7:0] MAKER_CODE = 8'h5C, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h03, // Arbitrary value
  parameter int CONV_COUNT = tsc_pkg::CONV_CYCLES
) (
  clock,
  reset,
  cmd,
  wr_en,
  wr_data,
  rd_en,
  rd_data,
  adc_data,
  diode_fault,
  halted,
  conv_active,
  temp_result
);
  import tsc_pkg::*;
  input wire logic clock;
  input wire logic reset;
  input wire logic [7:0] cmd;
  input wire logic wr_en;
  input wire logic [7:0] wr_data;
  input wire logic rd_en;
  output logic [7:0] rd_data;
  input wire logic [7:0] adc_data;
  input wire logic diode_fault;
  output logic halted;
  output logic conv_active;
  output logic [7:0] temp_result;

  tsc_conv_state_t state;
  tsc_conv_state_t next_state;
  logic [7:0] setup_register;
  logic [7:0] next_setup_register;
  logic [7:0] next_temp_result;
  logic [7:0] next_rd_data;
  logic next_halted;
  logic next_conv_active;
  logic setup_write;
  logic conv_done;
  logic fault_meta;
  logic fault_sync;

  // Write to setup is decoded from the command byte
  assign setup_write = wr_en && (cmd == CMD_SETUP);

  tsc_conv_timer #(
    .COUNT(CONV_COUNT)
  ) u_timer (
    .clock(clock),
    .reset(reset),
    .restart(setup_write),
    .run(state == TSC_CONVERT),
    .done(conv_done)
  );

  // Setup register; reserved bits stored as written and read back as written
  always_comb begin
    next_setup_register = setup_register;
    if (setup_write) begin
      next_setup_register = wr_data;
    end
  end

  // Converter sequencing; a write restarts so partial data is lost
  always_comb begin
    next_state = state;
    case (state)
      TSC_IDLE: begin
        // A halt written on the first cycle out of reset must still halt
        if (setup_write && wr_data[HALT_BIT]) begin
          next_state = TSC_HALTED;
        end else begin
          next_state = TSC_CONVERT;
        end
      end
      TSC_CONVERT: begin
        if (setup_write && wr_data[HALT_BIT]) begin
          next_state = TSC_HALTED;
        end
      end
      TSC_HALTED: begin
        if (setup_write && !wr_data[HALT_BIT]) begin
          next_state = TSC_CONVERT;
        end
      end
      default: begin
        next_state = TSC_IDLE;
      end
    endcase
  end

  // Result loads only on a clean finish, never on the write cycle
  always_comb begin
    next_temp_result = temp_result;
    if (conv_done && state == TSC_CONVERT && !setup_write) begin
      if (fault_sync) begin
        next_temp_result = FULL_SCALE;
      end else begin
        next_temp_result = adc_data;
      end
    end
  end

  // Read mux by command byte
  always_comb begin
    next_rd_data = rd_data;
    if (rd_en) begin
      case (cmd)
        CMD_TEMP: next_rd_data = temp_result;
        CMD_SETUP: next_rd_data = setup_register;
        CMD_MAKER: next_rd_data = MAKER_CODE;
        CMD_REV: next_rd_data = REVISION;
        default: next_rd_data = READ_UNMAPPED;
      endcase
    end
  end

  // Status outputs registered for clean timing
  always_comb begin
    next_halted = (next_state == TSC_HALTED);
    next_conv_active = (next_state == TSC_CONVERT);
  end

  // Fault flag comes from the analog side; two flops before any use.
  // A fault shorter than two cycles at conversion end may be missed.
  always_ff @(posedge clock) begin
    if (reset) begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
    end else begin
      fault_meta <= diode_fault;
      fault_sync <= fault_meta;
    end
  end

  // Converter state and the status outputs that follow it
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= TSC_IDLE;
      halted <= HALT_RESET;
      conv_active <= 1'b0;
    end else begin
      state <= next_state;
      halted <= next_halted;
      conv_active <= next_conv_active;
    end
  end

  // Setup register, halt bit clear out of reset
  always_ff @(posedge clock) begin
    if (reset) begin
      setup_register <= 8'h00;
    end else begin
      setup_register <= next_setup_register;
    end
  end

  // Temperature result register
  always_ff @(posedge clock) begin
    if (reset) begin
      temp_result <= TEMP_RESET;
    end else begin
      temp_result <= next_temp_result;
    end
  end

  // Read data register, holds between reads
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end
endmodule // tsc_regs

// *** verif/tsc_regs_sva.sv ***
// Port checker for the sensor register bank
`timescale 1ns/100ps
module tsc_regs_sva #(
  parameter logic [7:0] MAKER_CODE = 8'h5C,
  parameter logic [7:0] REVISION = 8'h03
) (
  input wire logic clock, reset, wr_en, rd_en, halted, conv_active,
  input wire logic [7:0] cmd, wr_data, rd_data, temp_result
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Setup write, and the commands that map to a register
  wire sw = wr_en && cmd == 8'h03;
  wire known = cmd inside {8'h01, 8'h03, 8'hFE, 8'hFF};
  a_halt_on: assert property (sw && wr_data[6] |=> halted)
    else $error("halt");
  a_abort_drop: assert property (sw |=> $stable(temp_result)[*4])
    else $error("abort");
  a_halt_keep: assert property (halted && !sw |=>
    !conv_active && $stable(temp_result)) else $error("halted");
  a_maker_read: assert property (rd_en && cmd == 8'hFE |=>
    rd_data == MAKER_CODE) else $error("maker");
  a_rev_read: assert property (rd_en && cmd == 8'hFF |=>
    rd_data == REVISION) else $error("rev");
  a_unmapped_rd: assert property (rd_en && !known |=> rd_data == 8'h00)
    else $error("unmapped");
  a_read_hold: assert property (!rd_en |=> $stable(rd_data))
    else $error("hold");
  a_setup_read: assert property (rd_en && cmd == 8'h03 |=>
    rd_data[6] == halted) else $error("readback");
endmodule // tsc_regs_sva
bind tsc_regs tsc_regs_sva #(.MAKER_CODE(MAKER_CODE), .REVISION(REVISION))
  chk(.*);

// *** verif/tsc_host.sv ***
// Host model doing single byte transfers
`timescale 1ns/100ps
module tsc_host (
  input wire logic clock,
  output logic [7:0] cmd = 8'h00, wr_data = 8'h00,
  output logic wr_en = 1'b0, rd_en = 1'b0
);
  // One-cycle strobe, then lines scrambled as if released
  task op(logic [7:0] c, d, logic w);
    @(negedge clock);
    {cmd, wr_data, wr_en, rd_en} = {c, d, w, !w};
    @(negedge clock);
    {cmd, wr_data, wr_en, rd_en} = {~c, ~d, 2'b00};
  endtask
endmodule // tsc_host

// *** verif/tsc_regs_tb.sv ***
// Bench for the sensor register bank
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  num_errors++; $display("BAD %0t %h", $time, a); end end
module tsc_regs_tb;
  import tsc_pkg::*;
  // Id values set here so the bench owns its expectations
  localparam logic [7:0] MAKER = 8'hA5; // Arbitrary value
  localparam logic [7:0] REV = 8'h07; // Arbitrary value
  localparam logic [17:0] IDLE_OUT = {HALT_RESET, 1'b0, TEMP_RESET, 8'h00};
  logic clock = 0, reset = 1, diode_fault = 0, wr_en, rd_en, halted;
  logic conv_active;
  logic [7:0] adc_data = 8'hE7, cmd, wr_data, rd_data, temp_result;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  tsc_host h(.*);
  // Short conversion count keeps the run brief
  tsc_regs #(
    .MAKER_CODE(MAKER),
    .REVISION(REV),
    .CONV_COUNT(8)
  ) uut(.*);
  task results;
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wt;
    repeat (30) @(negedge clock);
  endtask
  // Byte write, and byte read checked while its data stands
  task wr(logic [7:0] c, d);
    h.op(c, d, 1'b1);
  endtask
  task rd(logic [7:0] c, want);
    h.op(c, 8'h00, 1'b0);
    `CHK(rd_data, want)
  endtask
  initial forever #50 clock = ~clock;
  always @(posedge clock) if (++cyc > 900) begin
    num_errors++;
    results;
  end
  initial begin
    repeat (3) @(negedge clock);
    `CHK({halted, conv_active, temp_result, rd_data}, IDLE_OUT)
    // Halt written on the very first edge after reset release
    fork
      begin
        @(negedge clock);
        reset = 0;
      end
      wr(CMD_SETUP, 8'h40);
    join
    `CHK({halted, conv_active}, 2'h2)
    wr(CMD_SETUP, 8'h00);
    `CHK({halted, conv_active}, 2'h1)
    wr(CMD_MAKER, 8'h11);
    rd(CMD_MAKER, MAKER);
    rd(CMD_REV, REV);
    rd(8'h55, READ_UNMAPPED);
    wt;
    `CHK(temp_result, 8'hE7)
    rd(CMD_TEMP, 8'hE7);
    wr(CMD_SETUP, 8'h40);
    adc_data = 8'h19;
    diode_fault = 1;
    wt;
    `CHK(temp_result, 8'hE7)
    h.op(CMD_SETUP, 8'h00, 1'b0);
    `CHK({rd_data[HALT_BIT], halted, conv_active}, 3'h6)
    wr(CMD_SETUP, 8'h00);
    wt;
    `CHK(temp_result, FULL_SCALE)
    wr(CMD_SETUP, 8'h40);
    diode_fault = 0;
    repeat (8) wr(CMD_SETUP, 8'h00);
    `CHK(temp_result, FULL_SCALE)
    wt;
    `CHK(temp_result, 8'h19)
    // Second reset in mid-run clears everything, conversion resumes
    reset = 1;
    repeat (2) @(negedge clock);
    `CHK({halted, conv_active, temp_result, rd_data}, IDLE_OUT)
    reset = 0;
    adc_data = 8'h83;
    wt;
    `CHK(temp_result, 8'h83)
    adc_data = 8'h01;
    wt;
    `CHK(temp_result, 8'h01)
    results;
  end
endmodule // tsc_regs_tb
